/* File: lfs_fault_seq.v */
// Functional notes
// - Overvoltage: both drives off, flag on
// - Overvoltage: one mask cycle, then hiccup
// - Hiccup start discharges soft-start at once
// - Hiccup end releases discharge, restarts switching
// - LED overcurrent: after two cycles, hiccup
// - Output undervoltage: high off; thirty cycles, hiccup
// - Current limit ends low-side pulse each cycle
// - Current limit beyond 64 cycles: hiccup
// - Blank current limit, undervoltage 3 ms
// - Input undervoltage: both drives off, flag
// - Regulator undervoltage: low side off, flag
// - Restart only when both supplies good
// - Input restart soft-starts; regulator restart skips
// - Overtemperature: both off, flag, discharge, restart
// - High-side supply undervoltage: both off, restart
// - Faulted frequency pin: 350 kHz clock
// - Shorted compensation forces minimum duty
// - Flag asserted for every fault but per-cycle current limit, shorted compensation, faulted frequency pin
// - Blanking at start, wake, hiccup end
//
// Purpose: Fault protection sequencer for an LED converter
// Assumes: Fault inputs are asynchronous comparator levels
// Notes: Analog comparators and soft-start ramp are outside
`timescale 1ns/1ps
`include "lfs_consts.vh"
module lfs_fault_seq #(
  parameter HICCUP_CYC = `LFS_HICCUP_CYC,
  parameter BLANK_CYC = `LFS_BLANK_CYC
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Switching clock sources
  input wire osc_tick,
  input wire freq_set_pin_fault,
  // Fault detectors
  input wire ov_fixed,
  input wire ov_prog,
  input wire led_oc,
  input wire out_uv,
  input wire sw_ilim,
  input wire input_supply_uv,
  input wire internal_5v_supply_uv,
  input wire over_temp,
  input wire hs_supply_uv,
  input wire comp_short,
  input wire wake,
  // Drive outputs
  output reg high_side_gate_drive_q,
  output reg low_side_gate_drive_q,
  output reg fault_flag_n_q,
  output reg soft_start_node_dis_q,
  output reg min_duty_q,
  output reg sw_tick_q
);
  // ----------------------------------------------------------
  // States
  // ----------------------------------------------------------
  localparam ST_RUN = 3'd0;
  localparam ST_MASK = 3'd1;
  localparam ST_HICCUP = 3'd2;
  localparam ST_WAIT = 3'd3;
  localparam ST_SUPPLY = 3'd4;

  // ----------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------
  localparam NIN = 12;
  wire [NIN-1:0] raw;
  reg [NIN-1:0] s1_q;
  reg [NIN-1:0] s2_q;
  assign raw = {wake, comp_short, freq_set_pin_fault, osc_tick,
                hs_supply_uv, over_temp, internal_5v_supply_uv,
                input_supply_uv, sw_ilim, out_uv, led_oc,
                ov_fixed | ov_prog};
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi = gi + 1) begin : g_sync
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= raw[gi];
          s2_q[gi] <= s1_q[gi];
        end
      end
    end
  endgenerate
  wire ov_s = s2_q[0];
  wire oc_s = s2_q[1];
  wire ouv_s = s2_q[2];
  wire ilim_s = s2_q[3];
  wire vin_uv_s = s2_q[4];
  wire internal_5v_supply_uv_s = s2_q[5];
  wire ot_s = s2_q[6];
  wire hs_uv_s = s2_q[7];
  wire osc_s = s2_q[8];
  wire oscf_s = s2_q[9];
  wire comp_s = s2_q[10];
  wire wake_s = s2_q[11];

  // ----------------------------------------------------------
  // Switching clock enable
  // ----------------------------------------------------------
  // Fallback divider keeps the fault counters alive without OSC
  reg osc_d1_q;
  reg [9:0] div_q;
  wire div_hit = (div_q == (`LFS_DEF_DIV - 1));
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_d1_q <= 1'b0;
      div_q <= 10'h000;
      sw_tick_q <= 1'b0;
    end else begin
      osc_d1_q <= osc_s;
      div_q <= div_hit ? 10'h000 : div_q + 10'h001;
      if (oscf_s)
        sw_tick_q <= div_hit;
      else
        sw_tick_q <= osc_s && !osc_d1_q;
    end
  end

  // ----------------------------------------------------------
  // Blanking and hiccup timers
  // ----------------------------------------------------------
  reg [2:0] st_q;
  reg hic_load;
  reg blank_load;
  wire hic_busy;
  wire hic_done;
  wire blank_busy;
  lfs_timer u_hic (
    .clk(clk),
    .rst_b(rst_b),
    .load(hic_load),
    .len(HICCUP_CYC[`LFS_TMR_W-1:0]),
    .busy(hic_busy),
    .done_q(hic_done)
  );
  lfs_timer u_blank (
    .clk(clk),
    .rst_b(rst_b),
    .load(blank_load),
    .len(BLANK_CYC[`LFS_TMR_W-1:0]),
    .busy(blank_busy),
    .done_q()
  );

  // ----------------------------------------------------------
  // Fault-mask counters
  // ----------------------------------------------------------
  wire run = (st_q == ST_RUN);
  wire ov_hit;
  wire oc_hit;
  wire ouv_hit;
  wire ilim_hit;
  lfs_fault_cnt u_ov (
    .clk(clk), .rst_b(rst_b), .sw_tick(sw_tick_q),
    .fault(1'b1), .clear(st_q != ST_MASK),
    .limit(`LFS_OV_MASK), .hit_q(ov_hit)
  );
  lfs_fault_cnt u_oc (
    .clk(clk), .rst_b(rst_b), .sw_tick(sw_tick_q),
    .fault(oc_s), .clear(!run || blank_busy),
    .limit(`LFS_OC_MASK), .hit_q(oc_hit)
  );
  lfs_fault_cnt u_ouv (
    .clk(clk), .rst_b(rst_b), .sw_tick(sw_tick_q),
    .fault(ouv_s), .clear(!run || blank_busy),
    .limit(`LFS_UV_MASK), .hit_q(ouv_hit)
  );
  lfs_fault_cnt u_ilim (
    .clk(clk), .rst_b(rst_b), .sw_tick(sw_tick_q),
    .fault(ilim_s), .clear(!run || blank_busy),
    .limit(`LFS_ILIM_MASK), .hit_q(ilim_hit)
  );
  // Limit 0x40 trips on the 64th tick; one more gives "more than"
  reg ilim_hit_q;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      ilim_hit_q <= 1'b0;
    else if (!ilim_hit)
      ilim_hit_q <= 1'b0;
    else if (sw_tick_q && ilim_s)
      ilim_hit_q <= 1'b1;
  end

  // ----------------------------------------------------------
  // Cycle-by-cycle current limit
  // ----------------------------------------------------------
  // Cut holds to the next tick; a limit in the tick cycle wins
  reg ilim_cut_q;
  wire ilim_live = ilim_s && !blank_busy;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      ilim_cut_q <= 1'b0;
    else if (ilim_live)
      ilim_cut_q <= 1'b1;
    else if (sw_tick_q)
      ilim_cut_q <= 1'b0;
  end

  // One blanking window per wake, however long the pin stays high
  reg wake_d1_q;
  wire wake_rise = wake_s && !wake_d1_q;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      wake_d1_q <= 1'b0;
    else
      wake_d1_q <= wake_s;
  end

  // ----------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------
  wire supply_bad = vin_uv_s || internal_5v_supply_uv_s || hs_uv_s || ot_s;
  wire ouv_live = ouv_s && run && !blank_busy;
  wire any_fault = ov_s || supply_bad || ouv_live ||
                   (oc_s && run && !blank_busy);
  // These also take the high side, unlike a bare regulator dip
  wire hs_off_fault = vin_uv_s || hs_uv_s || ot_s;
  reg [2:0] st_d;
  reg hs_d;
  reg ls_d;
  reg flag_n_d;
  reg dis_d;
  always @* begin
    st_d = st_q;
    hs_d = high_side_gate_drive_q;
    ls_d = low_side_gate_drive_q;
    flag_n_d = fault_flag_n_q;
    dis_d = soft_start_node_dis_q;
    hic_load = 1'b0;
    blank_load = 1'b0;
    case (st_q)
      ST_RUN: begin
        hs_d = 1'b1;
        ls_d = !(ilim_live || ilim_cut_q);
        flag_n_d = 1'b1;
        dis_d = 1'b0;
        if (ov_s) begin
          st_d = ST_MASK;
          hs_d = 1'b0;
          ls_d = 1'b0;
          flag_n_d = 1'b0;
        end else if (oc_hit || ilim_hit_q || ouv_hit) begin
          st_d = ST_HICCUP;
          hs_d = 1'b0;
          ls_d = 1'b0;
          flag_n_d = 1'b0;
          dis_d = 1'b1;
          hic_load = 1'b1;
        end else if (ouv_live) begin
          hs_d = 1'b0;
          flag_n_d = 1'b0;
        end
      end
      ST_MASK: begin
        if (ov_hit) begin
          st_d = ST_HICCUP;
          dis_d = 1'b1;
          hic_load = 1'b1;
        end
      end
      ST_HICCUP: begin
        if (hic_done) begin
          dis_d = 1'b0;
          blank_load = 1'b1;
          if (any_fault) begin
            st_d = ST_WAIT;
          end else begin
            st_d = ST_RUN;
            hs_d = 1'b1;
            ls_d = 1'b1;
            flag_n_d = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        // Restart held off while overvoltage or a supply fault still stands
        if (!any_fault) begin
          st_d = ST_RUN;
          flag_n_d = 1'b1;
        end
      end
      ST_SUPPLY: begin
        hs_d = high_side_gate_drive_q && !hs_off_fault && !ov_s;
        flag_n_d = 1'b0;
        if (hs_off_fault)
          dis_d = 1'b1;
        if (!supply_bad && ov_s) begin
          // Overvoltage met while parked still earns its hiccup
          st_d = ST_MASK;
          hs_d = 1'b0;
          ls_d = 1'b0;
        end else if (!supply_bad) begin
          st_d = ST_RUN;
          dis_d = 1'b0;
          blank_load = 1'b1;
          flag_n_d = 1'b1;
        end
      end
      default: begin
        st_d = ST_HICCUP;
        hic_load = 1'b1;
      end
    endcase
    if (wake_rise && run)
      blank_load = 1'b1;
    // Supply and thermal faults pre-empt every other state
    if (supply_bad && (st_q != ST_SUPPLY)) begin
      st_d = ST_SUPPLY;
      ls_d = 1'b0;
      hs_d = high_side_gate_drive_q && !hs_off_fault && !ov_s;
      flag_n_d = 1'b0;
      dis_d = soft_start_node_dis_q || hs_off_fault;
      hic_load = 1'b0;
      blank_load = 1'b0;
    end
  end

  // ----------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_SUPPLY;
      high_side_gate_drive_q <= 1'b0;
      low_side_gate_drive_q <= 1'b0;
      fault_flag_n_q <= 1'b1;
      soft_start_node_dis_q <= 1'b1;
      min_duty_q <= 1'b0;
    end else begin
      st_q <= st_d;
      high_side_gate_drive_q <= hs_d;
      low_side_gate_drive_q <= ls_d;
      fault_flag_n_q <= flag_n_d;
      soft_start_node_dis_q <= dis_d;
      min_duty_q <= comp_s;
    end
  end
endmodule

/* File: lfs_consts.vh */
// Purpose: Constants for the LED fault sequencer
// Assumes: 100 MHz system clock
// Notes: Times in their own unit, counts derived from them
`ifndef LFS_CONSTS_VH
`define LFS_CONSTS_VH
`define LFS_CLK_KHZ 100000
`define LFS_HICCUP_US 26500
`define LFS_HICCUP_CYC (`LFS_HICCUP_US * (`LFS_CLK_KHZ / 1000))
`define LFS_BLANK_US 3000
`define LFS_BLANK_CYC (`LFS_BLANK_US * (`LFS_CLK_KHZ / 1000))
`define LFS_DEF_FREQ_KHZ 350
`define LFS_DEF_DIV (`LFS_CLK_KHZ / `LFS_DEF_FREQ_KHZ)
`define LFS_OV_MASK 8'h01
`define LFS_OC_MASK 8'h02
`define LFS_UV_MASK 8'h1e
`define LFS_ILIM_MASK 8'h40
`define LFS_CNT_W 8
`define LFS_TMR_W 24
`endif

/* File: lfs_fault_cnt.v */
// Purpose: Fault-mask counter on the switching clock enable
// Assumes: fault and clear are synchronous
// Notes: Hit once count exceeds limit-1 qualifying cycles
`timescale 1ns/1ps
`include "lfs_consts.vh"
module lfs_fault_cnt (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Control
  input wire sw_tick,
  input wire fault,
  input wire clear,
  input wire [`LFS_CNT_W-1:0] limit,
  // Result
  output reg hit_q
);
  reg [`LFS_CNT_W-1:0] cnt_q;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 8'h00;
      hit_q <= 1'b0;
    end else if (clear || !fault) begin
      cnt_q <= 8'h00;
      hit_q <= 1'b0;
    end else if (sw_tick && !hit_q) begin
      if (cnt_q + 8'h01 >= limit)
        hit_q <= 1'b1;
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

/* File: lfs_timer.v */
// Purpose: Load-and-run down counter
// Assumes: One clock domain
// Notes: done pulses one cycle when the count reaches zero
`timescale 1ns/1ps
`include "lfs_consts.vh"
module lfs_timer (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Control
  input wire load,
  input wire [`LFS_TMR_W-1:0] len,
  // Status
  output wire busy,
  output reg done_q
);
  reg [`LFS_TMR_W-1:0] cnt_q;

  assign busy = (cnt_q != 24'h000000);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 24'h000000;
      done_q <= 1'b0;
    end else begin
      done_q <= (cnt_q == 24'h000001) && !load;
      if (load)
        cnt_q <= len;
      else if (busy)
        cnt_q <= cnt_q - 24'h000001;
    end
  end
endmodule

/* File: lfs_fault_seq_assertions.sv */
// Purpose: Port checks for the fault sequencer
// Assumes: Three clocks from pin to output
// Notes: Bound into every lfs_fault_seq
`timescale 1ns/1ps
module lfs_fault_seq_chk (
  // Clock and reset
  input logic clk,
  input logic rst_b,
  // Faults
  input logic ov_prog,
  input logic input_supply_uv,
  input logic internal_5v_supply_uv,
  input logic over_temp,
  input logic hs_supply_uv,
  input logic comp_short,
  // Outputs
  input logic high_side_gate_drive_q,
  input logic low_side_gate_drive_q,
  input logic fault_flag_n_q,
  input logic soft_start_node_dis_q,
  input logic min_duty_q,
  input logic sw_tick_q
);
  // --------------------------------
  // Checks
  // --------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire hs = high_side_gate_drive_q;
  wire ls = low_side_gate_drive_q;
  wire fl = fault_flag_n_q;
  wire ds = soft_start_node_dis_q;
  AST_OV_OFF:
    assert property (ov_prog [*4] |-> !hs && !ls && !fl)
    else $error("drive on during overvoltage");
  AST_IN_UV:
    assert property (input_supply_uv [*4] |-> !hs && !ls && !fl)
    else $error("drive on during input undervoltage");
  AST_REG_UV:
    assert property (internal_5v_supply_uv [*4] |-> !ls && !fl)
    else $error("low side on during regulator undervoltage");
  AST_OT:
    assert property (over_temp [*4] |-> !ls && !fl && ds)
    else $error("overtemperature not handled");
  AST_HS_UV:
    assert property (hs_supply_uv [*4] |-> !hs && !ls && !fl)
    else $error("drive on during high side undervoltage");
  AST_MIN_DUTY:
    assert property (comp_short [*4] |-> min_duty_q)
    else $error("minimum duty not forced");
  AST_DIS_HOLD:
    assert property ((!(input_supply_uv || hs_supply_uv || over_temp)) [*4]
      ##0 $rose(ds) |-> ds [*8])
    else $error("discharge released too early");
  AST_DIS_LS:
    assert property (ds |-> !ls)
    else $error("low side on while discharging");
  AST_TICK:
    assert property (sw_tick_q |=> !sw_tick_q)
    else $error("switching tick longer than one cycle");
  cover property ($rose(ds));
  cover property ($fell(ds));
  cover property (!fl && ls && !hs);
endmodule
bind lfs_fault_seq lfs_fault_seq_chk chk (.clk, .rst_b, .ov_prog,
  .input_supply_uv, .internal_5v_supply_uv, .over_temp, .hs_supply_uv,
  .comp_short, .high_side_gate_drive_q, .low_side_gate_drive_q,
  .fault_flag_n_q, .soft_start_node_dis_q, .min_duty_q, .sw_tick_q);

/* File: lfs_partner.sv */
// Purpose: Oscillator pin and fault flag pull-up
// Assumes: Tick period of four clocks
// Notes: Oscillator stands still when stopped
`timescale 1ns/1ps
module lfs_partner (
  // Clock and control
  input logic clk,
  input logic run,
  // From the sequencer
  input logic flag_n,
  // Towards sequencer and bench
  output logic osc_tick,
  output logic flag_pin
);
  logic [1:0] div_q = 2'h0;
  // Dead pin gives no edges, not a stuck toggle
  always @(posedge clk) begin
    div_q <= run ? div_q + 2'h1 : 2'h0;
  end
  assign osc_tick = div_q[1];
  // Pull-up: high unless driven low
  assign flag_pin = (flag_n === 1'b0) ? 1'b0 : 1'b1;
endmodule

/* File: tb_top.sv */
// Purpose: Scenario bench for the fault sequencer
// Assumes: Short hiccup and blank counts
// Notes: One task per scenario
`timescale 1ns/1ps
module tb_top;
  localparam int HIC = 200;
  logic clk = 0, rst_b = 0, fsel = 0, wake = 0, run = 1;
  logic [9:0] flt = 10'h0;
  wire osc, hs, ls, fl, ds, md, tk, fpin;
  int error_cnt = 0, n_checks = 0;
  always #5 clk = ~clk;
  lfs_fault_seq #(.HICCUP_CYC(HIC), .BLANK_CYC(50)) DUT (
    .clk(clk), .rst_b(rst_b), .osc_tick(osc), .freq_set_pin_fault(fsel),
    .ov_fixed(flt[0]), .ov_prog(flt[1]), .led_oc(flt[2]), .out_uv(flt[3]),
    .sw_ilim(flt[4]), .input_supply_uv(flt[5]),
    .internal_5v_supply_uv(flt[6]), .over_temp(flt[7]),
    .hs_supply_uv(flt[8]), .comp_short(flt[9]), .wake(wake),
    .high_side_gate_drive_q(hs), .low_side_gate_drive_q(ls),
    .fault_flag_n_q(fl), .soft_start_node_dis_q(ds), .min_duty_q(md),
    .sw_tick_q(tk));
  lfs_partner far (.clk(clk), .run(run), .flag_n(fl), .osc_tick(osc),
    .flag_pin(fpin));
  // --------------------------------
  // Helpers
  // --------------------------------
  task chk(string n, logic e, logic g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %b seen %b", n, e, g);
    end
  endtask
  task cyc(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task put(logic [9:0] v);
    @(posedge clk);
    flt <= v;
    #1;
  endtask
  task wdis(logic v, output int n);
    n = 0;
    while (ds !== v && n < 9000) begin
      cyc(1);
      n++;
    end
    if (n >= 9000)
      chk("ds_wait", v, ds);
  endtask
  task outs(logic h, logic l, logic f);
    chk("hs", h, hs);
    chk("ls", l, ls);
    chk("flag", f, fl);
  endtask
  task clr;
    int n;
    put(10'h0);
    wdis(0, n);
    cyc(60);
    outs(1, 1, 1);
    chk("pin", 1, fpin);
  endtask
  // --------------------------------
  // Scenarios
  // --------------------------------
  task t_blank(logic w);
    @(posedge clk);
    wake <= w;
    @(posedge clk);
    wake <= 0;
    put(10'h8);
    cyc(10);
    chk("hs", 1, hs);
    put(10'h0);
    cyc(60);
    outs(1, 1, 1);
  endtask
  task t_ov(int b);
    int n;
    put(10'(1 << b));
    cyc(4);
    outs(0, 0, 0);
    wdis(1, n);
    chk("ov_wait", n < 20, 1);
    put(10'h0);
    wdis(0, n);
    chk("hiccup", n > HIC - 6 && n < HIC + 4, 1);
    clr;
  endtask
  task t_oc;
    int n;
    put(10'h4);
    wdis(1, n);
    chk("oc_wait", n > 4 && n < 30, 1);
    outs(0, 0, 0);
    clr;
  endtask
  task t_uv;
    int n;
    put(10'h8);
    cyc(4);
    outs(0, 1, 0);
    wdis(1, n);
    chk("uv_wait", n > 100 && n < 140, 1);
    outs(0, 0, 0);
    clr;
  endtask
  task t_ilim;
    int n;
    put(10'h10);
    cyc(4);
    chk("ls", 0, ls);
    cyc(150);
    put(10'h0);
    cyc(12);
    put(10'h10);
    wdis(1, n);
    chk("ilim_wait", n > 240 && n < 290, 1);
    outs(0, 0, 0);
    clr;
  endtask
  task t_sup;
    for (int b = 5; b < 9; b++) begin
      put(10'(1 << b));
      cyc(4);
      outs(b == 6, 0, 0);
      if (b == 6 || b == 7)
        chk("dis", b == 7, ds);
      clr;
    end
    put(10'h60);
    cyc(6);
    put(10'h20);
    cyc(20);
    chk("ls", 0, ls);
    clr;
  endtask
  task t_misc;
    int n;
    put(10'h200);
    cyc(4);
    chk("min_duty", 1, md);
    @(posedge clk);
    run <= 0;
    fsel <= 1;
    cyc(600);
    n = 0;
    repeat (2850) begin
      cyc(1);
      n += int'(tk);
    end
    chk("ticks", n == 10, 1);
    @(posedge clk);
    run <= 1;
    fsel <= 0;
    clr;
    chk("min_duty", 0, md);
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // --------------------------------
  // Sequence and watchdog
  // --------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1;
    t_blank(0);
    t_ov(0);
    t_ov(1);
    t_oc;
    t_blank(1);
    t_uv;
    t_ilim;
    t_sup;
    t_misc;
    end_of_test;
  end
  // Generous: the sequence needs about a seventh of this
  initial begin
    #400000;
    error_cnt++;
    end_of_test;
  end
endmodule
